// File: cpusup_top.v
// cpu supervisor: power-fail hold, button override, power-fail interrupt, watchdog
// assumes comparator results arrive as synchronous levels on clk_in
//
// Notes on behaviour
// - hold asserted immediately when supply monitor reports supply below trip level
// - hold kept at least 130 ms after supply recovers, including power-up
// - button override input is active low; outside party pulls it low
// - override input debounced; each accepted press gives at least 130 ms hold
// - override hold interval counted from release of the button, not press
// - primary hold output active low; complementary active-high copy also given
// - sensed voltage below threshold pulses interrupt low for at least 200 us
// - interrupt only after sensed voltage below threshold about 5 us continuously
// - no interrupt pulse until main supply has reached its trip level
// - watchdog counts only while hold is inactive, starting at hold release
// - each kick falling edge before expiry restarts the watchdog interval
// - watchdog expires when no kick edge arrives within one second
// - on expiry watchdog alarm output driven low for at least 130 ms
`timescale 1ns/1ps
`include "cpusup_map.vh"

module cpusup_top
#(
   parameter HOLD_CYC = `CPUSUP_HOLD_CYC,
   parameter WDOG_CYC = `CPUSUP_WDOG_CYC,
   parameter NMI_CYC  = `CPUSUP_NMI_CYC,
   parameter FILT_CYC = `CPUSUP_FILT_CYC,
   parameter TICK_DIV = `CPUSUP_TICK_DIV,
   parameter DEB_TICKS = `CPUSUP_DEB_TICKS
)
(
   // clock and reset
   input  wire clk_in,
   input  wire rst_in,
   // comparator levels: high while the voltage is above its trip level
   input  wire supply_ok_in,
   input  wire sense_ok_in,
   // processor side inputs
   input  wire button_override_n_in,
   input  wire kick_pulse_in,
   // processor side outputs
   output reg  proc_hold_n_out,
   output reg  proc_hold_out,
   output reg  power_fail_n_out,
   output reg  watchdog_alarm_n_out
);

   localparam W = 32;

   // -----------------------------------------------------------------
   // time base tick for debouncing
   // -----------------------------------------------------------------
   reg  [W-1:0] tick_cnt_r;
   reg          tick_r;

   // a slow tick keeps the debounce window long without a wide shift register
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         tick_cnt_r <= {W{1'b0}};
         tick_r     <= 1'b0;
      end
      else if (tick_cnt_r == TICK_DIV[W-1:0] - 32'h0000_0001)
      begin
         tick_cnt_r <= {W{1'b0}};
         tick_r     <= 1'b1;
      end
      else
      begin
         tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
         tick_r     <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // button debounce
   // -----------------------------------------------------------------
   reg  [7:0] deb_cnt_r;
   reg        pressed_r;
   wire       btn_low = ~button_override_n_in;

   // press accepted after consecutive low ticks; release when input high
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         deb_cnt_r <= 8'h00;
         pressed_r <= 1'b0;
      end
      else if (!btn_low)
      begin
         deb_cnt_r <= 8'h00;
         pressed_r <= 1'b0;
      end
      else if (tick_r)
      begin
         if (deb_cnt_r == DEB_TICKS[7:0] - 8'h01)
            pressed_r <= 1'b1;
         else
            deb_cnt_r <= deb_cnt_r + 8'h01;
      end
   end

   // -----------------------------------------------------------------
   // hold interval timer
   // -----------------------------------------------------------------
   reg  supply_ok_d_r;
   reg  pressed_d_r;
   wire supply_rise = supply_ok_in & ~supply_ok_d_r;
   wire btn_release = pressed_d_r & ~pressed_r;
   wire hold_busy;

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         supply_ok_d_r <= 1'b0;
         pressed_d_r   <= 1'b0;
      end
      else
      begin
         supply_ok_d_r <= supply_ok_in;
         pressed_d_r   <= pressed_r;
      end
   end

   // the interval starts at supply recovery or at button release
   cpusup_timer #(.WIDTH(W)) hold_tmr
   (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .start_in (supply_rise | btn_release),
      .load_in  (HOLD_CYC[W-1:0]),
      .busy_out (hold_busy)
   );

   // hold while supply low, button held, or interval running
   wire hold_nxt = ~supply_ok_in | pressed_r | btn_release | supply_rise | hold_busy;

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         proc_hold_n_out <= 1'b0;
         proc_hold_out   <= 1'b1;
      end
      else
      begin
         proc_hold_n_out <= ~hold_nxt;
         proc_hold_out   <= hold_nxt;
      end
   end

   // -----------------------------------------------------------------
   // power-fail interrupt
   // -----------------------------------------------------------------
   reg  [W-1:0] filt_cnt_r;
   reg          sense_low_r;
   reg          supply_seen_r;
   reg  [W-1:0] nmi_cnt_r;

   // filter: sense must stay low for the full window before it counts
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         filt_cnt_r    <= {W{1'b0}};
         sense_low_r   <= 1'b0;
         supply_seen_r <= 1'b0;
      end
      else
      begin
         if (supply_ok_in)
            supply_seen_r <= 1'b1;
         if (sense_ok_in)
         begin
            filt_cnt_r  <= {W{1'b0}};
            sense_low_r <= 1'b0;
         end
         else if (filt_cnt_r == FILT_CYC[W-1:0] - 32'h0000_0001)
            sense_low_r <= 1'b1;
         else
            filt_cnt_r <= filt_cnt_r + 32'h0000_0001;
      end
   end

   // one pulse per filtered fall; a fall seen before supply is up waits for it
   reg  sense_low_d_r;
   wire nmi_fire = sense_low_r & supply_seen_r & ~sense_low_d_r;

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sense_low_d_r    <= 1'b0;
         nmi_cnt_r        <= {W{1'b0}};
         power_fail_n_out <= 1'b1;
      end
      else
      begin
         // only record the fall once it is allowed to fire
         sense_low_d_r <= sense_low_r & supply_seen_r;
         if (nmi_fire)
         begin
            nmi_cnt_r        <= NMI_CYC[W-1:0] - 32'h0000_0001;
            power_fail_n_out <= 1'b0;
         end
         else if (nmi_cnt_r != {W{1'b0}})
            nmi_cnt_r <= nmi_cnt_r - 32'h0000_0001;
         else
            power_fail_n_out <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // watchdog
   // -----------------------------------------------------------------
   reg          kick_d_r;
   reg  [W-1:0] wd_cnt_r;
   reg  [W-1:0] alarm_cnt_r;
   wire         kick_fall = kick_d_r & ~kick_pulse_in;

   // counter frozen and cleared while hold is active, restarted by kicks
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         kick_d_r             <= 1'b1;
         wd_cnt_r             <= {W{1'b0}};
         alarm_cnt_r          <= {W{1'b0}};
         watchdog_alarm_n_out <= 1'b1;
      end
      else
      begin
         kick_d_r <= kick_pulse_in;
         if (!proc_hold_n_out || kick_fall)
            wd_cnt_r <= {W{1'b0}};
         else if (wd_cnt_r == WDOG_CYC[W-1:0] - 32'h0000_0001)
            wd_cnt_r <= {W{1'b0}}; // then a fresh interval
         else
            wd_cnt_r <= wd_cnt_r + 32'h0000_0001;

         if (proc_hold_n_out && !kick_fall && wd_cnt_r == WDOG_CYC[W-1:0] - 32'h0000_0001)
         begin
            alarm_cnt_r          <= HOLD_CYC[W-1:0] - 32'h0000_0001;
            watchdog_alarm_n_out <= 1'b0;
         end
         else if (alarm_cnt_r != {W{1'b0}})
            alarm_cnt_r <= alarm_cnt_r - 32'h0000_0001;
         else
            watchdog_alarm_n_out <= 1'b1;
      end
   end

endmodule // cpusup_top

// File: cpusup_map.vh
// timing constants for the cpu supervisor: times in their own units, counts derived at 250 mhz
// assumes the includer runs on a 4 ns clock
`ifndef CPUSUP_MAP_VH
`define CPUSUP_MAP_VH

`define CPUSUP_CLK_MHZ        250
`define CPUSUP_HOLD_MS        130
`define CPUSUP_HOLD_CYC       (`CPUSUP_HOLD_MS * 1000 * `CPUSUP_CLK_MHZ)
`define CPUSUP_NMI_US         200
`define CPUSUP_NMI_CYC        (`CPUSUP_NMI_US * `CPUSUP_CLK_MHZ)
`define CPUSUP_FILT_US        5
`define CPUSUP_FILT_CYC       (`CPUSUP_FILT_US * `CPUSUP_CLK_MHZ)
`define CPUSUP_WDOG_S         1
`define CPUSUP_WDOG_CYC       (`CPUSUP_WDOG_S * 1000000 * `CPUSUP_CLK_MHZ)
`define CPUSUP_TICK_DIV       250
`define CPUSUP_DEB_TICKS      4

`endif

// File: cpusup_timer.v
// one-shot down counter: loads on start, reports busy until it reaches zero
// assumes start is a synchronous one-cycle pulse
`timescale 1ns/1ps

module cpusup_timer
#(
   parameter WIDTH = 32
)
(
   // clock and reset
   input  wire             clk_in,
   input  wire             rst_in,
   // control
   input  wire             start_in,
   input  wire [WIDTH-1:0] load_in,
   // status
   output wire             busy_out
);

   reg [WIDTH-1:0] count_r;

   // restart wins over counting so a retrigger always yields a full interval
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         count_r <= {WIDTH{1'b0}};
      else if (start_in)
         count_r <= load_in;
      else if (count_r != {WIDTH{1'b0}})
         count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
   end

   assign busy_out = (count_r != {WIDTH{1'b0}});

endmodule // cpusup_timer

// File: cpusup_proc_model.sv
// processor model: gives the watchdog kick strobe while it runs
// assumes the supervisor clock and its hold output
`timescale 1ns/1ps
module cpusup_proc_model
#(
   parameter int KICK_GAP = 50
)
(
   // clock
   input  wire  clk_in,
   // bench enable and supervisor hold
   input  wire  kick_en_in,
   input  wire  hold_n_in,
   // kick strobe
   output logic kick_pulse_out = 1'b1
);
   int gap_r = 0;
   // a held processor runs no code, so it never kicks; gap kept well under the timeout
   // the strobe idles high like a pulled-up pin and dips low for one cycle per kick
   always @(negedge clk_in)
   begin
      gap_r <= (gap_r >= KICK_GAP - 1) ? 0 : gap_r + 1;
      kick_pulse_out <= !(kick_en_in && hold_n_in && (gap_r == 0));
   end
endmodule // cpusup_proc_model

// File: cpusup_asserts.sv
// checker: output timing of the supervisor against its inputs
// assumes it is bound into cpusup_top
`timescale 1ns/1ps
module cpusup_asserts
#(
   parameter int HOLD_CYC = 50,
   parameter int WDOG_CYC = 200,
   parameter int NMI_CYC  = 20,
   parameter int FILT_CYC = 5
)
(
   // clock and reset
   input wire clk_in,
   input wire rst_in,
   // watched ports
   input wire supply_ok_in,
   input wire sense_ok_in,
   input wire button_override_n_in,
   input wire kick_pulse_in,
   input wire proc_hold_n_out,
   input wire proc_hold_out,
   input wire power_fail_n_out,
   input wire watchdog_alarm_n_out
);
   int   ok_r, lo_r, pf_r, al_r, run_r;
   logic seen_r, kd_r;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // run lengths that each output timing hangs on
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         {ok_r, lo_r, pf_r, al_r, run_r} <= '0;
         seen_r <= 1'b0;
         kd_r   <= 1'b1; // matches the high idle level of the strobe
      end
      else
      begin
         ok_r <= (supply_ok_in && button_override_n_in) ? ok_r + 1 : 0;
         lo_r <= sense_ok_in ? 0 : lo_r + 1;
         pf_r <= power_fail_n_out ? 0 : pf_r + 1;
         al_r <= watchdog_alarm_n_out ? 0 : al_r + 1;
         seen_r <= seen_r | supply_ok_in;
         kd_r <= kick_pulse_in;
         // expiry restarts the interval, so the count restarts too
         run_r <= (!proc_hold_n_out || (kd_r && !kick_pulse_in) || $fell(watchdog_alarm_n_out)) ? 0 : run_r + 1;
      end
   end
   AST_SUPPLY_LOW: assert property (!supply_ok_in |=> !proc_hold_n_out)
      else $error("hold late");
   AST_HOLD_MIN: assert property ($rose(proc_hold_n_out) |-> ok_r >= HOLD_CYC)
      else $error("hold short");
   AST_PAIR: assert property (proc_hold_out != proc_hold_n_out)
      else $error("hold copy");
   AST_NMI_WIDTH: assert property ($rose(power_fail_n_out) |-> pf_r >= NMI_CYC)
      else $error("pf short");
   AST_NMI_FILT: assert property ($fell(power_fail_n_out) |-> lo_r >= FILT_CYC)
      else $error("pf unfiltered");
   AST_NMI_GATE: assert property (!seen_r |-> power_fail_n_out)
      else $error("pf early");
   AST_WDOG_EARLY: assert property ($fell(watchdog_alarm_n_out) |-> run_r >= WDOG_CYC - 3)
      else $error("alarm early");
   AST_WDOG_LATE: assert property (run_r <= WDOG_CYC + 4)
      else $error("alarm late");
   AST_ALARM_WIDTH: assert property ($rose(watchdog_alarm_n_out) |-> al_r >= HOLD_CYC)
      else $error("alarm short");
   C_PF: cover property ($fell(power_fail_n_out));
   C_WD: cover property ($fell(watchdog_alarm_n_out));
   C_HOLD: cover property ($rose(proc_hold_n_out));
endmodule // cpusup_asserts
bind cpusup_top cpusup_asserts #(.HOLD_CYC(HOLD_CYC), .WDOG_CYC(WDOG_CYC), .NMI_CYC(NMI_CYC), .FILT_CYC(FILT_CYC))
   cpusup_asserts_i (.clk_in, .rst_in, .supply_ok_in, .sense_ok_in, .button_override_n_in, .kick_pulse_in,
   .proc_hold_n_out, .proc_hold_out, .power_fail_n_out, .watchdog_alarm_n_out);

// File: cpusup_top_tb_top.sv
// bench: power-up, brown-out, button, power-fail and watchdog scenarios
// assumes shortened counts and the processor model on the kick strobe
`timescale 1ns/1ps
module cpusup_top_tb_top;
   localparam int HOLD = 50, WDOG = 200, NMI = 20, FILT = 5;
   logic clk_in = 0, rst_in = 1, sup = 0, sen = 0, btn_n = 1, ken = 0;
   wire  kick, hold_n, hold, pf_n, al_n;
   int   num_errors = 0, samples_checked = 0, n, t;
   always #2 clk_in = ~clk_in;
   cpusup_top #(.HOLD_CYC(HOLD), .WDOG_CYC(WDOG), .NMI_CYC(NMI), .FILT_CYC(FILT), .TICK_DIV(2), .DEB_TICKS(3))
      cpusup_top_i (.clk_in(clk_in), .rst_in(rst_in), .supply_ok_in(sup), .sense_ok_in(sen),
      .button_override_n_in(btn_n), .kick_pulse_in(kick), .proc_hold_n_out(hold_n), .proc_hold_out(hold),
      .power_fail_n_out(pf_n), .watchdog_alarm_n_out(al_n));
   cpusup_proc_model cpusup_proc_model_i (.clk_in(clk_in), .kick_en_in(ken), .hold_n_in(hold_n), .kick_pulse_out(kick));
   task automatic finish_test();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk_bit(string s, logic e, logic g);
      samples_checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("mismatch %s exp %b got %b", s, e, g);
      end
   endtask
   task automatic chk_cyc(string s, int lo, int hi, int g);
      samples_checked++;
      if (g < lo || g > hi)
      begin
         num_errors++;
         $display("mismatch %s exp %0d..%0d got %0d", s, lo, hi, g);
      end
   endtask
   task automatic idle(int c);
      repeat (c) @(negedge clk_in);
   endtask
   // counts cycles until output k shows v; a hang ends the run
   task automatic wait_for(int k, logic v, output int c);
      c = 0;
      while ((k == 0 ? hold_n : k == 1 ? pf_n : al_n) !== v)
      begin
         idle(1);
         c++;
         if (c > 2 * WDOG)
         begin
            chk_bit("wait", v, ~v);
            finish_test();
         end
      end
   endtask
   task automatic t_powerup();
      idle(40);
      chk_bit("pf_n early", 1, pf_n);
      chk_bit("hold_n", 0, hold_n);
      sup = 1;
      wait_for(1, 0, n);
      chk_cyc("pf at supply", 0, 4, n);
      wait_for(0, 1, t);
      chk_cyc("hold", HOLD, HOLD + 4, n + t);
      chk_bit("hold", 0, hold);
      sen = 1;
      wait_for(2, 0, n);
      chk_cyc("expiry", WDOG - 2, WDOG + 4, n);
      wait_for(2, 1, n);
      chk_cyc("alarm", HOLD, HOLD + 4, n);
      $display("powerup done");
   endtask
   task automatic t_brownout();
      ken = 1;
      sup = 0;
      idle(1);
      chk_bit("hold_n", 0, hold_n);
      sup = 1;
      wait_for(0, 1, n);
      chk_cyc("hold", HOLD, HOLD + 4, n);
      idle(3 * WDOG);
      chk_bit("al_n kicked", 1, al_n);
      $display("brownout done");
   endtask
   task automatic t_button();
      btn_n = 0;
      idle(3);
      btn_n = 1;
      idle(10);
      chk_bit("hold_n bounce", 1, hold_n);
      btn_n = 0;
      idle(30);
      chk_bit("hold_n press", 0, hold_n);
      btn_n = 1;
      wait_for(0, 1, n);
      chk_cyc("hold release", HOLD, HOLD + 4, n);
      $display("button done");
   endtask
   task automatic t_nmi();
      sen = 0;
      idle(3);
      sen = 1;
      idle(10);
      chk_bit("pf_n dip", 1, pf_n);
      sen = 0;
      wait_for(1, 0, n);
      chk_cyc("filter", FILT, FILT + 3, n);
      wait_for(1, 1, n);
      chk_cyc("pf width", NMI, NMI + 2, n);
      idle(30);
      chk_bit("pf_n once", 1, pf_n);
      sen = 1;
      $display("nmi done");
   endtask
   initial
   begin
      idle(2);
      rst_in = 0;
      t_powerup();
      t_brownout();
      t_button();
      t_nmi();
      finish_test();
   end
endmodule // cpusup_top_tb_top
